/* File: design/dcspl_pkg.sv */
// Shared constants and types of the sync pulse and capture block.
package dcspl_pkg;

    // ==========================================================
    // Register byte addresses
    localparam logic [15:0] ADDR_SYNC_B_STATUS = 16'h098f;
    localparam logic [15:0] ADDR_START = 16'h0990;
    localparam logic [15:0] ADDR_NEXT_B = 16'h0998;
    localparam logic [15:0] ADDR_CYCLE_A = 16'h09a0;
    localparam logic [15:0] ADDR_DELAY_B = 16'h09a4;
    localparam logic [15:0] ADDR_CAP_A_CTRL = 16'h09a8;
    localparam logic [15:0] ADDR_CAP_B_CTRL = 16'h09a9;
    localparam logic [15:0] ADDR_CAP_A_FLAGS = 16'h09ae;
    localparam logic [15:0] ADDR_CAP_B_FLAGS = 16'h09af;
    localparam logic [15:0] ADDR_CAP_A_RISE = 16'h09b0;
    localparam logic [15:0] ADDR_CAP_A_FALL = 16'h09b8;
    localparam logic [15:0] ADDR_CAP_B_RISE = 16'h09c0;
    localparam logic [15:0] ADDR_CAP_B_FALL = 16'h09c8;

    // ==========================================================
    // Register sizes in bytes
    localparam int TIME_BYTES = 8;
    localparam int WORD_BYTES = 4;
    localparam int LOW_HALF_BYTES = 4;
    localparam int CTRL_BYTES = 1;

    // ==========================================================
    // Field positions and reset values
    localparam int MODE_RISE_BIT = 0;
    localparam int MODE_FALL_BIT = 1;
    localparam int FLAG_RISE_BIT = 0;
    localparam int FLAG_FALL_BIT = 1;
    localparam int FLAG_PIN_BIT = 2;
    localparam int PEND_B_BIT = 0;
    localparam logic [63:0] TIME_RESET = 64'h0;
    localparam logic [31:0] WORD_RESET = 32'h0;
    localparam logic [1:0] CTRL_RESET = 2'h0;
    localparam logic [7:0] BYTE_RESET = 8'h00;

    // ==========================================================
    // Types
    typedef struct packed {
        logic rd;
        logic wr;
        logic [15:0] addr;
        logic [7:0] wdata;
    } dcspl_req_s;

    typedef enum logic [1:0] {SA_OFF, SA_RUN, SA_DONE} dcspl_sync_e;

    typedef struct packed {
        logic pinMeta;
        logic pinSync;
        logic pinLast;
        logic flagRise;
        logic flagFall;
        logic [63:0] riseTime;
        logic [63:0] fallTime;
    } dcspl_cap_state_s;

endpackage : dcspl_pkg

/* File: design/dcspl_capture_unit.sv */
// Edge time capture of one input pin against the system time.
`timescale 1ns/1ps
module dcspl_capture_unit (
    input wire logic clk,
    input wire logic nrst,
    input wire logic capturePin,
    input wire logic [63:0] sysTime,
    input wire logic [1:0] singleMode,
    input wire logic clearRise,
    input wire logic clearFall,
    output logic [63:0] riseTime,
    output logic [63:0] fallTime,
    output logic [2:0] flags
);
    dcspl_pkg::dcspl_cap_state_s state_r;
    dcspl_pkg::dcspl_cap_state_s state_nxt;
    logic riseEdge;
    logic fallEdge;
    logic modeRise;
    logic modeFall;

    // ==========================================================
    // Edge detection and capture
    always_comb begin
        state_nxt = state_r;
        modeRise = singleMode[dcspl_pkg::MODE_RISE_BIT];
        modeFall = singleMode[dcspl_pkg::MODE_FALL_BIT];
        // The first stage only feeds the second one.
        state_nxt.pinMeta = capturePin;
        state_nxt.pinSync = state_r.pinMeta;
        state_nxt.pinLast = state_r.pinSync;
        riseEdge = state_r.pinSync & ~state_r.pinLast;
        fallEdge = ~state_r.pinSync & state_r.pinLast;
        // A held single event is kept until its time is read out.
        if (riseEdge && (!modeRise || !state_r.flagRise || clearRise)) begin
            state_nxt.riseTime = sysTime;
        end
        if (fallEdge && (!modeFall || !state_r.flagFall || clearFall)) begin
            state_nxt.fallTime = sysTime;
        end
        // A new edge in the clearing cycle wins over the clear.
        state_nxt.flagRise = modeRise
            & ((state_r.flagRise & ~clearRise) | riseEdge);
        state_nxt.flagFall = modeFall
            & ((state_r.flagFall & ~clearFall) | fallEdge);
        if (!nrst) begin
            state_nxt = '0;
            state_nxt.riseTime = dcspl_pkg::TIME_RESET;
            state_nxt.fallTime = dcspl_pkg::TIME_RESET;
        end
    end

    always_ff @(posedge clk) begin
        state_r <= state_nxt;
    end

    assign riseTime = state_r.riseTime;
    assign fallTime = state_r.fallTime;
    assign flags = {state_r.pinLast, state_r.flagFall, state_r.flagRise};

    // ==========================================================
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    heldTime_a: assert property (
        modeRise && state_r.flagRise && !clearRise |=> $stable(riseTime))
        else $error("single-event rise time overwritten while flagged");
    contNoFlag_a: assert property (
        !modeRise && !modeFall |=> !flags[0] && !flags[1])
        else $error("event flag set in continuous mode");
    riseCapture_a: assert property (
        riseEdge && !modeRise |=> riseTime == $past(sysTime))
        else $error("rising edge time not captured");
    fallFlag_a: assert property (
        fallEdge && modeFall |=> flags[1])
        else $error("falling edge flag not set in single mode");

endmodule : dcspl_capture_unit

/* File: design/dcspl_top.sv */
// Sync pulse generation and input capture with dual-side register access.
`timescale 1ns/1ps
module dcspl_top (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [63:0] sysTime,
    input wire dcspl_pkg::dcspl_req_s netReq,
    input wire dcspl_pkg::dcspl_req_s hostReq,
    input wire logic syncOwnerHost,
    input wire logic captureAOwnerHost,
    input wire logic captureBOwnerHost,
    input wire logic systemTimeHost,
    input wire logic unitActive,
    input wire logic autoActivate,
    input wire logic writeAckEnable,
    input wire logic frameEnd,
    input wire logic captureInA,
    input wire logic captureInB,
    output logic [7:0] netRdata,
    output logic [7:0] hostRdata,
    output logic syncPulseA,
    output logic syncPulseB,
    output logic appEventClear,
    output logic autoActivateReq
);
    typedef struct packed {
        logic [63:0] nextA;
        logic [63:0] nextB;
        logic [31:0] cycleA;
        logic [31:0] delayB;
        logic [1:0] ctrlA;
        logic [1:0] ctrlB;
        dcspl_pkg::dcspl_sync_e syncState;
        logic pendB;
        logic lowWr;
        logic highWr;
        logic pulseA;
        logic pulseB;
        logic eventClr;
        logic autoReq;
        logic [7:0] netRdata;
        logic [7:0] hostRdata;
    } dcspl_top_state_s;

    dcspl_top_state_s state_r;
    dcspl_top_state_s state_nxt;

    dcspl_pkg::dcspl_req_s syncReq;
    dcspl_pkg::dcspl_req_s capAReq;
    dcspl_pkg::dcspl_req_s capBReq;
    logic capAOwnerHost;
    logic hostAck;
    logic fire;
    logic fireB;
    logic startWr;
    logic [1:0] capPin;
    logic [1:0][1:0] capMode;
    logic [1:0] capOwnerHost;
    logic [1:0][15:0] capRiseAddr;
    logic [1:0][15:0] capFallAddr;
    logic [1:0] clrRise;
    logic [1:0] clrFall;
    logic [1:0][63:0] capRise;
    logic [1:0][63:0] capFall;
    logic [1:0][2:0] capFlags;
    localparam logic [7:0] BYTE0 = dcspl_pkg::BYTE_RESET;

    // ==========================================================
    // Byte access helpers
    function automatic logic hitWin(input logic [15:0] addr,
                                    input logic [15:0] base,
                                    input int bytes);
        logic [15:0] off;
        off = addr - base;
        hitWin = (off < 16'(bytes));
    endfunction : hitWin

    function automatic logic [7:0] pickByte(input logic [63:0] v,
                                            input logic [15:0] addr,
                                            input logic [15:0] base,
                                            input int bytes);
        logic [15:0] off;
        off = addr - base;
        pickByte = BYTE0;
        if (hitWin(addr, base, bytes)) begin
            pickByte = v[{off[2:0], 3'h0} +: 8];
        end
    endfunction : pickByte

    function automatic logic [63:0] putByte(input logic [63:0] v,
                                            input dcspl_pkg::dcspl_req_s r,
                                            input logic [15:0] base,
                                            input int bytes);
        logic [15:0] off;
        logic [63:0] res;
        off = r.addr - base;
        res = v;
        if (r.wr && hitWin(r.addr, base, bytes)) begin
            res[{off[2:0], 3'h0} +: 8] = r.wdata;
        end
        putByte = res;
    endfunction : putByte

    // Reserved bits of every register read as zero.
    function automatic logic [7:0] readByte(input logic [15:0] addr);
        readByte =
            pickByte(state_r.nextA, addr, dcspl_pkg::ADDR_START,
                     dcspl_pkg::TIME_BYTES)
          | pickByte(state_r.nextB, addr, dcspl_pkg::ADDR_NEXT_B,
                     dcspl_pkg::TIME_BYTES)
          | pickByte({32'h0, state_r.cycleA}, addr, dcspl_pkg::ADDR_CYCLE_A,
                     dcspl_pkg::WORD_BYTES)
          | pickByte({32'h0, state_r.delayB}, addr, dcspl_pkg::ADDR_DELAY_B,
                     dcspl_pkg::WORD_BYTES)
          | pickByte({62'h0, state_r.ctrlA}, addr, dcspl_pkg::ADDR_CAP_A_CTRL,
                     dcspl_pkg::CTRL_BYTES)
          | pickByte({62'h0, state_r.ctrlB}, addr, dcspl_pkg::ADDR_CAP_B_CTRL,
                     dcspl_pkg::CTRL_BYTES)
          | pickByte({61'h0, capFlags[0]}, addr, dcspl_pkg::ADDR_CAP_A_FLAGS,
                     dcspl_pkg::CTRL_BYTES)
          | pickByte({61'h0, capFlags[1]}, addr, dcspl_pkg::ADDR_CAP_B_FLAGS,
                     dcspl_pkg::CTRL_BYTES)
          | pickByte({63'h0, state_r.pendB}, addr,
                     dcspl_pkg::ADDR_SYNC_B_STATUS, dcspl_pkg::CTRL_BYTES)
          | pickByte(capRise[0], addr, dcspl_pkg::ADDR_CAP_A_RISE,
                     dcspl_pkg::TIME_BYTES)
          | pickByte(capFall[0], addr, dcspl_pkg::ADDR_CAP_A_FALL,
                     dcspl_pkg::TIME_BYTES)
          | pickByte(capRise[1], addr, dcspl_pkg::ADDR_CAP_B_RISE,
                     dcspl_pkg::TIME_BYTES)
          | pickByte(capFall[1], addr, dcspl_pkg::ADDR_CAP_B_FALL,
                     dcspl_pkg::TIME_BYTES);
    endfunction : readByte

    // ==========================================================
    // Ownership and access steering
    always_comb begin
        syncReq = syncOwnerHost ? hostReq : netReq;
        capAOwnerHost = captureAOwnerHost | systemTimeHost;
        capAReq = capAOwnerHost ? hostReq : netReq;
        capBReq = captureBOwnerHost ? hostReq : netReq;
        // Write-ack mode moves the side effect from host read to host write.
        hostAck = writeAckEnable ? hostReq.wr : hostReq.rd;
        startWr = syncReq.wr && !unitActive
            && hitWin(syncReq.addr, dcspl_pkg::ADDR_START,
                      dcspl_pkg::TIME_BYTES);
        fire = (state_r.syncState == dcspl_pkg::SA_RUN) && unitActive
            && (sysTime >= state_r.nextA);
        fireB = state_r.pendB && unitActive && (sysTime >= state_r.nextB);
    end

    // ==========================================================
    // Capture inputs
    assign capPin = {captureInB, captureInA};
    assign capMode = {state_r.ctrlB, state_r.ctrlA};
    assign capOwnerHost = {captureBOwnerHost, capAOwnerHost};
    assign capRiseAddr = {dcspl_pkg::ADDR_CAP_B_RISE,
                          dcspl_pkg::ADDR_CAP_A_RISE};
    assign capFallAddr = {dcspl_pkg::ADDR_CAP_B_FALL,
                          dcspl_pkg::ADDR_CAP_A_FALL};

    generate
        for (genvar i = 0; i < 2; i++) begin : gCap
            // Only a read of the low byte (a host write in write-ack mode) acknowledges the event.
            assign clrRise[i] = capOwnerHost[i]
                ? (hostAck && hostReq.addr == capRiseAddr[i])
                : (netReq.rd && netReq.addr == capRiseAddr[i]);
            assign clrFall[i] = capOwnerHost[i]
                ? (hostAck && hostReq.addr == capFallAddr[i])
                : (netReq.rd && netReq.addr == capFallAddr[i]);
            dcspl_capture_unit uCap (
                .clk(clk),
                .nrst(nrst),
                .capturePin(capPin[i]),
                .sysTime(sysTime),
                .singleMode(capMode[i]),
                .clearRise(clrRise[i]),
                .clearFall(clrFall[i]),
                .riseTime(capRise[i]),
                .fallTime(capFall[i]),
                .flags(capFlags[i])
            );
        end
    endgenerate

    // ==========================================================
    // Register writes, pulse generation and read answers
    always_comb begin
        logic [63:0] tmpWord;
        logic [63:0] tmpStart;
        state_nxt = state_r;
        tmpWord = 64'h0;
        tmpStart = state_r.nextA;

        if (startWr) begin
            tmpStart = putByte(state_r.nextA, syncReq,
                               dcspl_pkg::ADDR_START,
                               dcspl_pkg::TIME_BYTES);
            if (hitWin(syncReq.addr, dcspl_pkg::ADDR_START,
                       dcspl_pkg::LOW_HALF_BYTES)) begin
                state_nxt.lowWr = 1'b1;
            end else begin
                state_nxt.highWr = 1'b1;
            end
        end
        state_nxt.nextA = tmpStart;

        tmpWord = putByte({32'h0, state_r.cycleA}, syncReq,
                          dcspl_pkg::ADDR_CYCLE_A, dcspl_pkg::WORD_BYTES);
        state_nxt.cycleA = tmpWord[31:0];
        tmpWord = putByte({32'h0, state_r.delayB}, syncReq,
                          dcspl_pkg::ADDR_DELAY_B, dcspl_pkg::WORD_BYTES);
        state_nxt.delayB = tmpWord[31:0];
        if (capAReq.wr && capAReq.addr == dcspl_pkg::ADDR_CAP_A_CTRL) begin
            state_nxt.ctrlA = capAReq.wdata[1:0];
        end
        if (capBReq.wr && capBReq.addr == dcspl_pkg::ADDR_CAP_B_CTRL) begin
            state_nxt.ctrlB = capBReq.wdata[1:0];
        end

        // A frame that wrote only the low half gets its upper half from
        // the current time, rolled forward when the low half has wrapped.
        state_nxt.autoReq = 1'b0;
        if (frameEnd) begin
            if (autoActivate && state_r.lowWr && !state_r.highWr
                && !unitActive) begin
                state_nxt.nextA[63:32] = sysTime[63:32]
                    + 32'(state_r.nextA[31:0] < sysTime[31:0]);
            end
            state_nxt.autoReq = autoActivate
                && (state_r.lowWr || state_r.highWr);
            state_nxt.lowWr = 1'b0;
            state_nxt.highWr = 1'b0;
        end

        state_nxt.pulseA = 1'b0;
        unique case (state_r.syncState)
            dcspl_pkg::SA_OFF: begin
                if (unitActive) begin
                    state_nxt.syncState = dcspl_pkg::SA_RUN;
                end
            end
            dcspl_pkg::SA_RUN: begin
                if (!unitActive) begin
                    state_nxt.syncState = dcspl_pkg::SA_OFF;
                end else if (fire) begin
                    state_nxt.pulseA = 1'b1;
                    state_nxt.nextB = state_r.nextA
                        + {32'h0, state_r.delayB};
                    if (state_r.cycleA == dcspl_pkg::WORD_RESET) begin
                        state_nxt.syncState = dcspl_pkg::SA_DONE;
                    end else begin
                        state_nxt.nextA = state_r.nextA
                            + {32'h0, state_r.cycleA};
                    end
                end
            end
            dcspl_pkg::SA_DONE: begin
                if (!unitActive) begin
                    state_nxt.syncState = dcspl_pkg::SA_OFF;
                end
            end
        endcase

        // A pending second-stream pulse is replaced by a newer one.
        state_nxt.pulseB = fireB;
        state_nxt.pendB = fire || (state_r.pendB && !fireB);

        state_nxt.eventClr = (writeAckEnable ? hostReq.wr : hostReq.rd)
            && hostReq.addr == dcspl_pkg::ADDR_SYNC_B_STATUS;
        state_nxt.netRdata = netReq.rd ? readByte(netReq.addr) : BYTE0;
        state_nxt.hostRdata = hostReq.rd ? readByte(hostReq.addr) : BYTE0;

        if (!nrst) begin
            state_nxt = '0;
            state_nxt.nextA = dcspl_pkg::TIME_RESET;
            state_nxt.nextB = dcspl_pkg::TIME_RESET;
            state_nxt.cycleA = dcspl_pkg::WORD_RESET;
            state_nxt.delayB = dcspl_pkg::WORD_RESET;
            state_nxt.ctrlA = dcspl_pkg::CTRL_RESET;
            state_nxt.ctrlB = dcspl_pkg::CTRL_RESET;
            state_nxt.syncState = dcspl_pkg::SA_OFF;
        end
    end

    always_ff @(posedge clk) begin
        state_r <= state_nxt;
    end

    assign netRdata = state_r.netRdata;
    assign hostRdata = state_r.hostRdata;
    assign syncPulseA = state_r.pulseA;
    assign syncPulseB = state_r.pulseB;
    assign appEventClear = state_r.eventClr;
    assign autoActivateReq = state_r.autoReq;

    // ==========================================================
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    sequence sFire;
        fire && state_r.cycleA != 32'h0;
    endsequence

    sequence sAdvance;
        syncPulseA && state_r.nextA == $past(state_r.nextA)
            + {32'h0, $past(state_r.cycleA)};
    endsequence

    pulseAdvance_a: assert property (
        sFire |=> sAdvance)
        else $error("pulse did not advance next time by cycle");
    singleShot_a: assert property (
        fire && state_r.cycleA == 32'h0 |=> syncPulseA
            ##1 (!syncPulseA [*3]))
        else $error("single-shot mode gave more than one pulse");
    activeLock_a: assert property (
        unitActive && !fire |=> $stable(state_r.nextA))
        else $error("start time changed while unit active");
    ownerOnly_a: assert property (
        !syncOwnerHost && hostReq.wr && !netReq.wr && !unitActive
            && !frameEnd |=> $stable(state_r.nextA)
            && $stable(state_r.cycleA))
        else $error("non-owner side changed sync registers");
    startRead_a: assert property (
        netReq.rd && netReq.addr == dcspl_pkg::ADDR_START
            |=> netRdata == $past(state_r.nextA[7:0]))
        else $error("start register read not next pulse time");
    nextBRead_a: assert property (
        hostReq.rd && hostReq.addr == dcspl_pkg::ADDR_NEXT_B
            |=> hostRdata == $past(state_r.nextB[7:0]))
        else $error("next second pulse time read wrong");
    eventClear_a: assert property (
        !writeAckEnable && hostReq.rd
            && hostReq.addr == dcspl_pkg::ADDR_SYNC_B_STATUS
            |=> appEventClear ##1 !appEventClear || $past(hostReq.rd))
        else $error("host read of sync status did not clear event");
    upperExtend_a: assert property (
        frameEnd && autoActivate && state_r.lowWr && !state_r.highWr
            && !unitActive |=> state_r.nextA[63:32] == $past(sysTime[63:32])
            + 32'($past(state_r.nextA[31:0]) < $past(sysTime[31:0])))
        else $error("upper start time not extended");

endmodule : dcspl_top

/* File: tb/dcspl_bus_master.sv */
// Network and host register masters driving byte accesses.
`timescale 1ns/1ps
module dcspl_bus_master (
    input wire logic clk,
    output dcspl_pkg::dcspl_req_s netReq,
    output dcspl_pkg::dcspl_req_s hostReq,
    input wire logic [7:0] netRdata,
    input wire logic [7:0] hostRdata
);
    // ==========================================================
    // Byte access
    initial begin
        netReq = '0;
        hostReq = '0;
    end
    // The strobe stands over exactly one taking edge, so no access repeats.
    task automatic acc(input bit hs, input bit wr, input logic [15:0] a,
            input logic [7:0] d, output logic [7:0] q);
        dcspl_pkg::dcspl_req_s r;
        r = '{rd: !wr, wr: wr, addr: a, wdata: d};
        @(posedge clk);
        if (hs) hostReq <= r;
        else netReq <= r;
        @(posedge clk);
        if (hs) hostReq <= '0;
        else netReq <= '0;
        @(negedge clk);
        q = hs ? hostRdata : netRdata;
    endtask : acc
    task automatic rw(input bit hs, input bit wr, input logic [15:0] a,
            input int n, inout logic [63:0] v);
        logic [7:0] q;
        for (int i = 0; i < n; i++) begin
            acc(hs, wr, a + 16'(i), v[8*i +: 8], q);
            if (!wr) v[8*i +: 8] = q;
        end
    endtask : rw
endmodule : dcspl_bus_master

/* File: tb/dcspl_top_tb.sv */
// Self-checking bench of the sync pulse and capture block.
`timescale 1ns/1ps
module dcspl_top_tb;
    // ==========================================================
    // Stimulus and observation
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic [63:0] sysTime = 64'h0;
    logic syncOwnerHost = 1'b0;
    logic captureAOwnerHost = 1'b0;
    logic systemTimeHost = 1'b0;
    logic autoActivate = 1'b0;
    logic frameEnd = 1'b0;
    logic unitActive = 1'b0;
    logic writeAckEnable = 1'b0;
    logic captureInA = 1'b0;
    logic [7:0] netRdata, hostRdata;
    logic syncPulseA, syncPulseB, appEventClear, autoActivateReq;
    dcspl_pkg::dcspl_req_s netReq, hostReq;
    int nA = 0;
    int nEv = 0;
    int nB = 0;
    int nAuto = 0;
    int nFail = 0;
    int nChecks = 0;
    always #4 clk = ~clk;
    always @(posedge clk) sysTime <= sysTime + 64'h8;
    always @(negedge clk) begin
        nA <= nA + int'(syncPulseA);
        nEv <= nEv + int'(appEventClear);
        nB <= nB + int'(syncPulseB);
        nAuto <= nAuto + int'(autoActivateReq);
    end
    dcspl_top dcspl_top_i (.clk(clk), .nrst(nrst), .sysTime(sysTime),
        .netReq(netReq), .hostReq(hostReq), .syncOwnerHost(syncOwnerHost),
        .captureAOwnerHost(captureAOwnerHost), .captureBOwnerHost(1'b0),
        .systemTimeHost(systemTimeHost), .unitActive(unitActive),
        .autoActivate(autoActivate), .writeAckEnable(writeAckEnable),
        .frameEnd(frameEnd), .captureInA(captureInA), .captureInB(1'b0),
        .netRdata(netRdata), .hostRdata(hostRdata),
        .syncPulseA(syncPulseA), .syncPulseB(syncPulseB),
        .appEventClear(appEventClear),
        .autoActivateReq(autoActivateReq));
    dcspl_bus_master dcspl_bus_master_i (.clk(clk), .netReq(netReq),
        .hostReq(hostReq), .netRdata(netRdata), .hostRdata(hostRdata));
    // ==========================================================
    // Helpers
    task automatic io(input bit hs, input bit wr, input logic [15:0] a,
            input int n, inout logic [63:0] v);
        if (!wr) v = 64'h0;
        dcspl_bus_master_i.rw(hs, wr, a, n, v);
    endtask : io
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        nChecks++;
        if (seen !== exp) begin
            nFail++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic finalReport();
        $display("checks %0d mismatches %0d", nChecks, nFail);
        if (nFail == 0 && nChecks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : finalReport
    task automatic waitA(input int b);
        for (int i = 0; i < 1000 && nA == b; i++) @(posedge clk);
        if (nA == b) begin
            nFail++;
            finalReport();
        end
    endtask : waitA
    task automatic pin(input logic lvl, output logic [63:0] t);
        @(posedge clk);
        captureInA <= lvl;
        t = sysTime;
        repeat (8) @(posedge clk);
    endtask : pin
    // ==========================================================
    // Scenarios
    task automatic testSync();
        logic [63:0] v;
        logic [63:0] t;
        io(1'b1, 1'b0, 16'h0990, 8, v);
        check(v, 64'h0);
        v = 64'h4000;
        io(1'b1, 1'b1, 16'h09a0, 4, v);
        io(1'b0, 1'b0, 16'h09a0, 4, v);
        check(v, 64'h0);
        v = 64'h4000;
        io(1'b0, 1'b1, 16'h09a0, 4, v);
        io(1'b0, 1'b0, 16'h09a0, 4, v);
        check(v, 64'h4000);
        v = 64'h10;
        io(1'b0, 1'b1, 16'h09a4, 4, v);
        t = sysTime + 64'h800;
        v = t;
        io(1'b0, 1'b1, 16'h0990, 8, v);
        @(posedge clk);
        unitActive <= 1'b1;
        v = t + 64'h100;
        io(1'b0, 1'b1, 16'h0990, 8, v);
        io(1'b0, 0, 16'h0990, 8, v);
        check(v, t);
        waitA(0);
        check(sysTime, t + 64'h8);
        io(1'b0, 1'b0, 16'h0990, 8, v);
        check(v, t + 64'h4000);
        io(1'b1, 1'b0, 16'h0998, 8, v);
        check(v, t + 64'h10);
        check(64'(nB), 64'h1);
        $display("sync test done");
    endtask : testSync
    task automatic testShot();
        logic [63:0] v;
        int b;
        @(posedge clk);
        unitActive <= 1'b0;
        v = 64'h0;
        io(1'b0, 1'b1, 16'h09a0, 4, v);
        v = sysTime + 64'h400;
        io(1'b0, 1'b1, 16'h0990, 8, v);
        b = nA;
        @(posedge clk);
        unitActive <= 1'b1;
        waitA(b);
        repeat (600) @(posedge clk);
        check(64'(nA - b), 64'h1);
        $display("single shot test done");
    endtask : testShot
    task automatic testCapture();
        logic [63:0] v;
        logic [63:0] t;
        logic [63:0] rt;
        v = 64'hff;
        io(1'b0, 1'b1, 16'h09a8, 1, v);
        v = 64'h0;
        io(1'b1, 1'b1, 16'h09a8, 1, v);
        io(1'b1, 1'b0, 16'h09a8, 1, v);
        check(v, 64'h3);
        pin(1'b1, t);
        io(1'b0, 1'b0, 16'h09ae, 1, v);
        check(v, 64'h5);
        pin(1'b0, rt);
        pin(1'b1, rt);
        io(1'b0, 1'b0, 16'h09ae, 1, v);
        check(v, 64'h7);
        io(1'b0, 1'b0, 16'h09b0, 8, rt);
        check(rt, t + 64'h18);
        io(1'b0, 1'b0, 16'h09ae, 1, v);
        check(v, 64'h6);
        io(1'b0, 1'b0, 16'h09b8, 8, v);
        io(1'b0, 1'b0, 16'h09ae, 1, v);
        check(v, 64'h4);
        v = 64'h0;
        io(1'b0, 1'b1, 16'h09a8, 1, v);
        pin(1'b0, rt);
        pin(1'b1, t);
        io(1'b0, 1'b0, 16'h09b0, 8, v);
        check(v, t + 64'h18);
        io(1'b0, 1'b0, 16'h09ae, 1, v);
        check(v, 64'h4);
        v = 64'hff;
        io(1'b0, 1'b1, 16'h09a9, 1, v);
        io(1'b0, 1'b0, 16'h09a9, 1, v);
        check(v, 64'h3);
        @(posedge clk);
        systemTimeHost <= 1'b1;
        v = 64'h2;
        io(1'b1, 1'b1, 16'h09a8, 1, v);
        v = 64'h3;
        io(1'b0, 1'b1, 16'h09a8, 1, v);
        io(1'b0, 1'b0, 16'h09a8, 1, v);
        check(v, 64'h2);
        @(posedge clk);
        systemTimeHost <= 1'b0;
        $display("capture test done");
    endtask : testCapture
    task automatic testEvent();
        logic [63:0] v;
        int b;
        b = nEv;
        io(1'b1, 1'b0, 16'h098f, 1, v);
        io(1'b1, 1'b1, 16'h098f, 1, v);
        repeat (2) @(posedge clk);
        check(64'(nEv - b), 64'h1);
        @(posedge clk);
        writeAckEnable <= 1'b1;
        io(1'b1, 1'b0, 16'h098f, 1, v);
        io(1'b1, 1'b1, 16'h098f, 1, v);
        @(posedge clk);
        writeAckEnable <= 1'b0;
        repeat (2) @(posedge clk);
        check(64'(nEv - b), 64'h2);
        $display("event test done");
    endtask : testEvent
    task automatic testAuto();
        logic [63:0] v;
        @(posedge clk);
        unitActive <= 1'b0;
        frameEnd <= 1'b1;
        @(posedge clk);
        frameEnd <= 1'b0;
        autoActivate <= 1'b1;
        v = 64'h10;
        io(1'b0, 1'b1, 16'h0990, 4, v);
        @(posedge clk);
        frameEnd <= 1'b1;
        @(posedge clk);
        frameEnd <= 1'b0;
        autoActivate <= 1'b0;
        io(1'b0, 1'b0, 16'h0990, 8, v);
        check(v, 64'h0000_0001_0000_0010);
        check(64'(nAuto), 64'h1);
        $display("auto extension test done");
    endtask : testAuto
    initial begin
        repeat (12) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        testSync();
        testShot();
        testCapture();
        testEvent();
        testAuto();
        finalReport();
    end
endmodule : dcspl_top_tb
